// ---- include/nvsc_params.svh ----
/*
 * constants for the nonvolatile static ram controller: pin timing in ns,
 * derived cycle counts and the software trigger addresses.
 * assumes mclk at 125 mhz and a device whose memory pins are wired straight to this block.
 */
// Overview of operation
// - host keeps address stable through each write
// - write data valid for window before write end
// - host keeps output enable high during writes
// - store busy pin pulled low requests store
// - host starts no access while store busy low
// - six fixed reads trigger a software store
// - same five reads then 0x4c63 trigger recall
`ifndef NVSC_PARAMS_SVH
`define NVSC_PARAMS_SVH

`define NVSC_CLK_NS       8
`define NVSC_ADDR_W       17
`define NVSC_DATA_W       8
`define NVSC_TMR_W        16
// access and pin times, ns
`define NVSC_ACCESS_NS    45
`define NVSC_WR_WINDOW_NS 20
`define NVSC_PULL_NS      50
`define NVSC_XFER_NS      15000
`define NVSC_PWRUP_NS     20000
// least times round up to whole cycles
`define NVSC_ACCESS_CYC ((`NVSC_ACCESS_NS + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)
`define NVSC_WR_WINDOW_CYC ((`NVSC_WR_WINDOW_NS + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)
`define NVSC_PULL_CYC   ((`NVSC_PULL_NS + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)
`define NVSC_XFER_CYC   ((`NVSC_XFER_NS + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)
`define NVSC_PWRUP_CYC  ((`NVSC_PWRUP_NS + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)
// trigger sequence
`define NVSC_SEQ_LAST     3'h5
`define NVSC_SEQ_A0       17'h04e38
`define NVSC_SEQ_A1       17'h0b1c7
`define NVSC_SEQ_A2       17'h083e0
`define NVSC_SEQ_A3       17'h07c1f
`define NVSC_SEQ_A4       17'h0703f
`define NVSC_SEQ_STORE    17'h08fc0
`define NVSC_SEQ_RECALL   17'h04c63

`endif

// ---- include/nvsc_pkg.sv ----
/*
 * types shared by the nonvolatile static ram controller modules.
 * assumes nvsc_params.svh is on the include path.
 */
package nvsc_pkg;
	// user commands
	typedef enum logic [2:0] {
		OP_READ,
		OP_WRITE,
		OP_SW_STORE,
		OP_SW_RECALL,
		OP_PIN_STORE
	} nvsc_op_e;

	// controller sequencing
	typedef enum logic [2:0] {
		ST_PWRUP,
		ST_IDLE,
		ST_SETUP,
		ST_ACCESS,
		ST_END,
		ST_PULL,
		ST_XFER
	} nvsc_state_e;
endpackage : nvsc_pkg

// ---- logic/nvsc_timer.sv ----
/*
 * down counter used for every timed phase of the controller.
 * assumes load is a one-cycle request from the owner and en freezes it.
 */
`timescale 1ns/1ns
`include "nvsc_params.svh"
module nvsc_timer (
	// clock, reset and enable
	input  wire logic                   mclk,
	input  wire logic                   resetn,
	input  wire logic                   en,
	// control
	input  wire logic                   load,
	input  wire logic [`NVSC_TMR_W-1:0] load_val,
	// status
	output logic                        done
);
	logic [`NVSC_TMR_W-1:0] count_reg;
	logic [`NVSC_TMR_W-1:0] count_next;

	// load wins, otherwise count to zero and park
	always_comb begin
		count_next = count_reg;
		if (load) begin
			count_next = load_val;
		end else if (count_reg != '0) begin
			count_next = count_reg - 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			count_reg <= '0;
		end else if (en) begin
			count_reg <= count_next;
		end
	end

	assign done = (count_reg == '0);
endmodule : nvsc_timer

// ---- logic/nvsc_ctrl.sv ----
/*
 * host controller for a byte-wide nonvolatile static ram: reads, writes,
 * software store and recall sequences and the store busy pull request.
 * assumes the device pins are wired directly, the pin inputs are synchronous
 * to mclk and an external pull-up sits on the store busy wire.
 */
`timescale 1ns/1ns
`include "nvsc_params.svh"
module nvsc_ctrl (
	// clock, reset, enable
	input  wire logic                      mclk,
	input  wire logic                      resetn,
	input  wire logic                      en,
	// user command port
	input  wire logic                      cmd_valid,
	input  nvsc_pkg::nvsc_op_e             cmd_op,
	input  wire logic [`NVSC_ADDR_W-1:0]   cmd_addr,
	input  wire logic [`NVSC_DATA_W-1:0]   cmd_wdata,
	output logic                           cmd_ready,
	output logic                           rd_valid,
	output logic [`NVSC_DATA_W-1:0]        rd_data,
	output logic                           op_done,
	// memory control pins
	output logic                           mem_ce_n,
	output logic                           mem_oe_n,
	output logic                           mem_we_n,
	output logic [`NVSC_ADDR_W-1:0]        addr_bus,
	// data pins, three signals
	input  wire logic [`NVSC_DATA_W-1:0]   data_bus_i,
	output logic [`NVSC_DATA_W-1:0]        data_bus_o,
	output logic                           data_bus_oe_n,
	// store busy pin, open drain
	input  wire logic                      store_busy_n_i,
	output logic                           store_busy_n_o,
	output logic                           store_busy_n_oe_n
);
	import nvsc_pkg::*;

	localparam logic [`NVSC_TMR_W-1:0] ACC_LOAD   = `NVSC_TMR_W'(`NVSC_ACCESS_CYC - 1);
	localparam logic [`NVSC_TMR_W-1:0] PULL_LOAD  = `NVSC_TMR_W'(`NVSC_PULL_CYC - 1);
	localparam logic [`NVSC_TMR_W-1:0] XFER_LOAD  = `NVSC_TMR_W'(`NVSC_XFER_CYC - 1);
	localparam logic [`NVSC_TMR_W-1:0] PWRUP_LOAD = `NVSC_TMR_W'(`NVSC_PWRUP_CYC - 1);

	// trigger address for each step of a software sequence
	function automatic logic [`NVSC_ADDR_W-1:0] seq_addr(input logic [2:0] idx,
	                                                     input logic recall);
		logic [`NVSC_ADDR_W-1:0] a;
		a = `NVSC_SEQ_A0;
		case (idx)
			3'h1: a = `NVSC_SEQ_A1;
			3'h2: a = `NVSC_SEQ_A2;
			3'h3: a = `NVSC_SEQ_A3;
			3'h4: a = `NVSC_SEQ_A4;
			3'h5: a = recall ? `NVSC_SEQ_RECALL : `NVSC_SEQ_STORE;
			default: a = `NVSC_SEQ_A0;
		endcase
		return a;
	endfunction : seq_addr

	nvsc_state_e             state_reg,   state_next;
	nvsc_op_e                op_reg,      op_next;
	logic [2:0]              idx_reg,     idx_next;
	logic                    ce_n_reg,    ce_n_next;
	logic                    oe_n_reg,    oe_n_next;
	logic                    we_n_reg,    we_n_next;
	logic [`NVSC_ADDR_W-1:0] addr_reg,    addr_next;
	logic [`NVSC_DATA_W-1:0] wdata_reg,   wdata_next;
	logic                    doe_n_reg,   doe_n_next;
	logic                    pull_n_reg,  pull_n_next;
	logic                    ready_reg,   ready_next;
	logic                    rvalid_reg,  rvalid_next;
	logic [`NVSC_DATA_W-1:0] rdata_reg,   rdata_next;
	logic                    done_reg,    done_next;
	logic                    busy_low_reg;
	logic                    tmr_load;
	logic [`NVSC_TMR_W-1:0]  tmr_val;
	logic                    tmr_done;
	logic                    is_sw;

	nvsc_timer u_timer (
		.mclk     (mclk),
		.resetn   (resetn),
		.en       (en),
		.load     (tmr_load),
		.load_val (tmr_val),
		.done     (tmr_done)
	);

	assign is_sw = (op_reg == OP_SW_STORE) || (op_reg == OP_SW_RECALL);

	// sequencing and pin levels; every pin comes from a register
	always_comb begin
		state_next  = state_reg;
		op_next     = op_reg;
		idx_next    = idx_reg;
		ce_n_next   = 1'b1;
		oe_n_next   = 1'b1;
		we_n_next   = 1'b1;
		addr_next   = addr_reg;
		wdata_next  = wdata_reg;
		doe_n_next  = 1'b1;
		pull_n_next = 1'b1;
		ready_next  = 1'b0;
		rvalid_next = 1'b0;
		rdata_next  = rdata_reg;
		done_next   = 1'b0;
		tmr_load    = 1'b0;
		tmr_val     = ACC_LOAD;
		case (state_reg)
			ST_PWRUP: begin
				// device restores its array first, so wait it out
				tmr_load   = 1'b1;
				tmr_val    = PWRUP_LOAD;
				state_next = ST_XFER;
			end
			ST_IDLE: begin
				ready_next = store_busy_n_i;
				if (cmd_valid && ready_reg && store_busy_n_i) begin
					op_next   = cmd_op;
					idx_next  = 3'h0;
					wdata_next = cmd_wdata;
					if (cmd_op == OP_PIN_STORE) begin
						pull_n_next = 1'b0;
						tmr_load    = 1'b1;
						tmr_val     = PULL_LOAD;
						state_next  = ST_PULL;
					end else if (cmd_op == OP_SW_STORE || cmd_op == OP_SW_RECALL) begin
						addr_next  = seq_addr(3'h0, cmd_op == OP_SW_RECALL);
						state_next = ST_SETUP;
					end else begin
						addr_next  = cmd_addr;
						doe_n_next = (cmd_op != OP_WRITE);
						state_next = ST_SETUP;
					end
				end
			end
			ST_SETUP: begin
				// address settled a cycle before select falls
				ce_n_next  = 1'b0;
				we_n_next  = (op_reg != OP_WRITE);
				oe_n_next  = (op_reg == OP_WRITE);
				doe_n_next = (op_reg != OP_WRITE);
				tmr_load   = 1'b1;
				tmr_val    = ACC_LOAD;
				state_next = ST_ACCESS;
			end
			ST_ACCESS: begin
				// address and data frozen while strobes are low
				doe_n_next = (op_reg != OP_WRITE);
				if (tmr_done) begin
					if (op_reg == OP_READ) begin
						rdata_next = data_bus_i;
					end
					state_next = ST_END;
				end else begin
					ce_n_next = 1'b0;
					we_n_next = we_n_reg;
					oe_n_next = oe_n_reg;
				end
			end
			ST_END: begin
				// strobes high again; one cycle of hold, then the next step
				if (is_sw && idx_reg != `NVSC_SEQ_LAST) begin
					idx_next   = idx_reg + 3'h1;
					addr_next  = seq_addr(idx_reg + 3'h1, op_reg == OP_SW_RECALL);
					state_next = ST_SETUP;
				end else if (is_sw) begin
					tmr_load   = 1'b1;
					tmr_val    = XFER_LOAD;
					state_next = ST_XFER;
				end else begin
					rvalid_next = (op_reg == OP_READ);
					done_next   = 1'b1;
					ready_next  = store_busy_n_i;
					state_next  = ST_IDLE;
				end
			end
			ST_PULL: begin
				pull_n_next = tmr_done;
				if (tmr_done) begin
					tmr_load   = 1'b1;
					tmr_val    = XFER_LOAD;
					state_next = ST_XFER;
				end
			end
			ST_XFER: begin
				// device is deaf now; stay off the pins until busy clears
				if (tmr_done && store_busy_n_i && busy_low_reg == 1'b0) begin
					done_next  = 1'b1; // store, recall, pin store and the power-up wait end here
					ready_next = 1'b1;
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// register stage only
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_reg    <= ST_PWRUP;
			op_reg       <= OP_READ;
			idx_reg      <= 3'h0;
			ce_n_reg     <= 1'b1;
			oe_n_reg     <= 1'b1;
			we_n_reg     <= 1'b1;
			addr_reg     <= 17'h00000;
			wdata_reg    <= 8'h00;
			doe_n_reg    <= 1'b1;
			pull_n_reg   <= 1'b1;
			ready_reg    <= 1'b0;
			rvalid_reg   <= 1'b0;
			rdata_reg    <= 8'h00;
			done_reg     <= 1'b0;
			busy_low_reg <= 1'b0;
		end else if (en) begin
			state_reg    <= state_next;
			op_reg       <= op_next;
			idx_reg      <= idx_next;
			ce_n_reg     <= ce_n_next;
			oe_n_reg     <= oe_n_next;
			we_n_reg     <= we_n_next;
			addr_reg     <= addr_next;
			wdata_reg    <= wdata_next;
			doe_n_reg    <= doe_n_next;
			pull_n_reg   <= pull_n_next;
			ready_reg    <= ready_next;
			rvalid_reg   <= rvalid_next;
			rdata_reg    <= rdata_next;
			done_reg     <= done_next;
			busy_low_reg <= ~store_busy_n_i; // one cycle of debounce after release
		end
	end

	// pin and port drive
	assign mem_ce_n          = ce_n_reg;
	assign mem_oe_n          = oe_n_reg;
	assign mem_we_n          = we_n_reg;
	assign addr_bus          = addr_reg;
	assign data_bus_o        = wdata_reg;
	assign data_bus_oe_n     = doe_n_reg;
	assign store_busy_n_o    = 1'b0; // open drain: only ever pulls low
	assign store_busy_n_oe_n = pull_n_reg;
	assign cmd_ready         = ready_reg;
	assign rd_valid          = rvalid_reg;
	assign rd_data           = rdata_reg;
	assign op_done           = done_reg;

	// checks; a frozen enable suspends them
	localparam int PULL_MAX = 16;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn || !en);

	sequence s_write_low;
		!ce_n_reg && !we_n_reg;
	endsequence

	sequence s_write_open;
		$fell(we_n_reg) ##0 !ce_n_reg;
	endsequence

	a_oe_high_write: assert property (!we_n_reg |-> oe_n_reg)
		else $error("output enable low during write");
	a_no_contention: assert property (!doe_n_reg |-> oe_n_reg)
		else $error("host drives data while device may drive");
	a_addr_stable_write: assert property (s_write_low |=> $stable(addr_reg))
		else $error("address moved during write");
	a_data_window_write: assert property (s_write_open |-> !doe_n_reg && $stable(wdata_reg))
		else $error("write data not valid when strobe fell");
	// three cycles at 8 ns cover the 20 ns data window
	a_write_length: assert property (s_write_open |-> (!we_n_reg && !doe_n_reg)[*3])
		else $error("write data window too short");
	a_busy_no_start: assert property (state_reg == ST_IDLE && !store_busy_n_i |=> state_reg == ST_IDLE)
		else $error("access started while store busy low");
	a_pull_release: assert property ($fell(pull_n_reg) |-> ##[1:PULL_MAX] pull_n_reg)
		else $error("store busy pull not released");
	a_seq_reads_only: assert property (is_sw && state_reg != ST_IDLE |-> we_n_reg)
		else $error("write inside trigger sequence");
	a_seq_last_addr: assert property (state_reg == ST_END && is_sw && idx_reg == 3'h5
		|-> addr_reg == ((op_reg == OP_SW_RECALL) ? 17'h04c63 : 17'h08fc0))
		else $error("wrong final trigger address");
endmodule : nvsc_ctrl

// ---- testbench/nvsc_dev_model.sv ----
/*
 * behavioural model of the byte-wide nonvolatile static ram at the far side of nvsc_ctrl.
 * assumes mclk as its time base and a tb that resolves the data and store busy wires.
 */
`timescale 1ns/1ns
`include "nvsc_params.svh"
module nvsc_dev_model #(
	parameter int XFER_CYC = 1000,
	parameter int HOLD_CYC = 4
) (
	// time base
	input  wire logic        mclk,
	// memory pins
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic [16:0] addr,
	input  wire logic [7:0]  din,
	output logic [7:0]       dout,
	output logic             drive,
	// store busy wire and supply sense
	input  wire logic        busy_n,
	output logic             pull,
	input  wire logic        pwr_fail
);
	bit   [7:0]  sram [131072];
	bit   [7:0]  nv [131072];
	bit          pending;
	bit          in_wr;
	bit          was_rd;
	bit          hold_done;
	bit          pf_prev;
	logic [16:0] wa;
	logic [16:0] ra;
	logic [7:0]  wd;
	int          xfer;
	int          hold;
	int          idx;
	int          stores;
	logic        idle_reg = 1'b1;
	logic [16:0] seq_a [5] = '{`NVSC_SEQ_A0, `NVSC_SEQ_A1, `NVSC_SEQ_A2, `NVSC_SEQ_A3,
		`NVSC_SEQ_A4};
	wire         rd = !ce_n && we_n && busy_n && idle_reg;

	// power-up copy of the shadow cells
	initial sram = nv;
	assign drive = rd && !oe_n;
	assign dout = sram[addr];
	assign pull = !idle_reg;

	// whole array moves in one step, no byte walk
	task automatic start(input bit st);
		if (st) begin
			nv = sram;
			stores++;
		end else begin
			sram = '{default: 8'h00};
			sram = nv;
		end
		xfer = XFER_CYC;
	endtask : start

	// trigger sequence tracker, any stray access restarts it
	task automatic step(input logic [16:0] a);
		if (idx == 5) begin
			if (a == `NVSC_SEQ_STORE) start(1'b1);
			else if (a == `NVSC_SEQ_RECALL) start(1'b0);
			idx = 0;
		end else idx = (a == seq_a[idx]) ? idx + 1 : int'(a == seq_a[0]);
	endtask : step

	// pin sampling; busy output is registered so the host never races it
	always @(posedge mclk) begin
		if (xfer > 0) begin
			xfer--;
			if (xfer == 0) pending = 1'b0;
		end else begin
			if (!ce_n && !we_n && busy_n) begin
				wa = addr;
				wd = din;
				in_wr = 1'b1;
				idx = 0;
			end else if (in_wr) begin
				sram[wa] = wd;
				pending = 1'b1;
				in_wr = 1'b0;
			end
			if (was_rd && (!rd || addr != ra)) step(ra);
			was_rd = rd;
			ra = addr;
			hold = busy_n ? 0 : hold + 1;
			if (busy_n) hold_done = 1'b0;
			if (hold == HOLD_CYC && !hold_done) begin
				hold_done = 1'b1;
				if (pending) start(1'b1);
			end
			if (pwr_fail && !pf_prev && pending) start(1'b1);
			pf_prev = pwr_fail;
		end
		idle_reg <= (xfer == 0);
	end
endmodule : nvsc_dev_model

// ---- testbench/tb_nvsc_ctrl.sv ----
/*
 * self-checking bench for nvsc_ctrl against the device model.
 * assumes the full-length transfer and power-up counts of nvsc_params.svh.
 */
`timescale 1ns/1ns
`include "nvsc_params.svh"
module tb_nvsc_ctrl;
	import nvsc_pkg::*;
	logic        mclk = 1'b0;
	logic        resetn = 1'b0;
	logic        en = 1'b1;
	logic        cmd_valid = 1'b0;
	logic        pwr_fail = 1'b0;
	nvsc_op_e    cmd_op = OP_READ;
	logic [16:0] cmd_addr = 17'h00000;
	logic [7:0]  cmd_wdata = 8'h00;
	logic [7:0]  float_pat = 8'h5a;
	logic        cmd_ready, rd_valid, op_done, mem_ce_n, mem_oe_n, mem_we_n;
	logic [16:0] addr_bus;
	logic [7:0]  rd_data, data_bus_o, dev_dout;
	logic        data_bus_oe_n, store_busy_n_o, store_busy_n_oe_n, dev_drv, dev_pull;
	wire  [7:0]  data_bus_i;
	wire         busy_w;
	bit   [7:0]  exp_mem [131072];
	logic [7:0]  rq [$];
	logic [31:0] rnd = 32'hbf5d;
	logic [16:0] a;
	int          failures, checks, cyc, base;

	always #4 mclk = ~mclk;
	// released lines wander so a stale value never reads as good data
	always @(posedge mclk) float_pat <= ~float_pat;
	assign data_bus_i = (data_bus_oe_n === 1'b0) ? data_bus_o : dev_drv ? dev_dout : float_pat;
	assign busy_w = ((store_busy_n_oe_n === 1'b0) ? store_busy_n_o : 1'b1) & ~dev_pull;

	nvsc_ctrl uut (.mclk(mclk), .resetn(resetn), .en(en), .cmd_valid(cmd_valid),
		.cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
		.rd_valid(rd_valid), .rd_data(rd_data), .op_done(op_done), .mem_ce_n(mem_ce_n),
		.mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n), .addr_bus(addr_bus),
		.data_bus_i(data_bus_i), .data_bus_o(data_bus_o), .data_bus_oe_n(data_bus_oe_n),
		.store_busy_n_i(busy_w), .store_busy_n_o(store_busy_n_o),
		.store_busy_n_oe_n(store_busy_n_oe_n));
	nvsc_dev_model dev (.mclk(mclk), .ce_n(mem_ce_n), .oe_n(mem_oe_n), .we_n(mem_we_n),
		.addr(addr_bus), .din(data_bus_i), .dout(dev_dout), .drive(dev_drv),
		.busy_n(busy_w), .pull(dev_pull), .pwr_fail(pwr_fail));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
	endfunction : lfsr

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wrap_up();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : wrap_up

	// one command; waits for ready first so nothing starts while busy is low
	task automatic cmd(input nvsc_op_e op, input logic [16:0] ad, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		while (cmd_ready !== 1'b1) begin
			@(posedge mclk);
			n++;
			if (n > 6000) begin failures++; wrap_up(); end
		end
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_addr <= ad;
		cmd_wdata <= d;
		if (op == OP_READ) rq.push_back(exp_mem[ad]);
		if (op == OP_WRITE) exp_mem[ad] = d;
		@(posedge mclk);
		cmd_valid <= 1'b0;
		rnd = lfsr(rnd);
		if (rnd[0]) begin // random freeze mid command
			en <= 1'b0;
			repeat (3) @(posedge mclk);
			en <= 1'b1;
		end
		n = 0;
		while (op_done !== 1'b1) begin
			@(posedge mclk);
			n++;
			if (n > 6000) begin failures++; wrap_up(); end
		end
	endtask : cmd

	// read results are matched against the oldest note
	always @(posedge mclk) begin
		if (rd_valid === 1'b1) begin
			if (rq.size() == 0) failures++;
			else check(rd_data, rq.pop_front());
		end
	end

	// hang guard, about three times the expected run
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 40000) begin failures++; wrap_up(); end
	end

	initial begin
		repeat (20) @(posedge mclk);
		check({7'h0, mem_ce_n}, 8'h01);
		resetn <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			a = (i == 0) ? 17'h00000 : (i == 1) ? 17'h1ffff : rnd[16:0];
			cmd(OP_WRITE, a, rnd[31:24]);
			cmd(OP_READ, a, 8'h00);
		end
		a = 17'h00123;
		cmd(OP_WRITE, a, 8'ha5);
		base = dev.stores;
		cmd(OP_SW_STORE, 17'h0, 8'h0);
		check(dev.nv[a], 8'ha5);
		cmd(OP_WRITE, a, 8'h3c);
		cmd(OP_SW_RECALL, 17'h0, 8'h0);
		exp_mem[a] = 8'ha5;
		cmd(OP_READ, a, 8'h00);
		cmd(OP_PIN_STORE, 17'h0, 8'h0);
		check(8'(dev.stores - base), 8'h01);
		cmd(OP_SW_STORE, 17'h0, 8'h0);
		check(8'(dev.stores - base), 8'h02);
		cmd(OP_WRITE, a, 8'h77);
		cmd(OP_PIN_STORE, 17'h0, 8'h0);
		check(8'(dev.stores - base), 8'h03);
		check(dev.nv[a], 8'h77);
		// broken trigger sequence must not store
		cmd(OP_READ, `NVSC_SEQ_A0, 8'h00);
		cmd(OP_READ, `NVSC_SEQ_A1, 8'h00);
		cmd(OP_WRITE, a, 8'h99);
		cmd(OP_READ, `NVSC_SEQ_A2, 8'h00);
		cmd(OP_READ, `NVSC_SEQ_A3, 8'h00);
		cmd(OP_READ, `NVSC_SEQ_A4, 8'h00);
		cmd(OP_READ, `NVSC_SEQ_STORE, 8'h00);
		check(8'(dev.stores - base), 8'h03);
		// supply loss with a write pending
		@(posedge mclk);
		pwr_fail <= 1'b1;
		repeat (6) @(posedge mclk);
		check({7'h0, cmd_ready}, 8'h00);
		pwr_fail <= 1'b0;
		check(8'(dev.stores - base), 8'h04);
		check(dev.nv[a], 8'h99);
		cmd(OP_READ, a, 8'h00);
		repeat (4) @(posedge mclk);
		check(8'(rq.size()), 8'h00);
		wrap_up();
	end
endmodule : tb_nvsc_ctrl
